// file: hw/sssr_pkg.sv
// Function
// - rising shift clock moves register, loads data
// - strobe high: latch follows; low: holds
// - parallel outputs driven only when enabled
// - disabled: parallel outputs float, cascades run
// - early cascade shows last stage, rising edge
// - late cascade updates on falling edge only
package sssr_pkg;

   // ***************************************************
   // shape of the block
   // ***************************************************
   localparam int SSSR_STAGES = 8;
   localparam int SSSR_SYNC_LEN = 2;
   localparam int SSSR_FIFO_DEPTH = 16;
   localparam int SSSR_PIN_COUNT = 4;

   // ***************************************************
   // pin slots inside the synchroniser bank
   // ***************************************************
   localparam int SSSR_PIN_CLOCK = 0;
   localparam int SSSR_PIN_DATA = 1;
   localparam int SSSR_PIN_STROBE = 2;
   localparam int SSSR_PIN_DRIVE = 3;

   // ***************************************************
   // reset values
   // ***************************************************
   localparam logic [SSSR_STAGES-1:0] SSSR_SHIFT_RESET = 8'h00;
   localparam logic [SSSR_STAGES-1:0] SSSR_LATCH_RESET = 8'h00;
   localparam logic [SSSR_PIN_COUNT-1:0] SSSR_SYNC_RESET = 4'h0;
   localparam logic SSSR_BIT_RESET = 1'b0;

   // ***************************************************
   // timing
   // ***************************************************
   localparam int SSSR_SYS_PERIOD_NS = 8;
   // shortest legal shift clock half period, two samples each side
   localparam int SSSR_MIN_HALF_NS = 16;
   localparam int SSSR_MIN_HALF_CYCLES =
      (SSSR_MIN_HALF_NS + SSSR_SYS_PERIOD_NS - 1) / SSSR_SYS_PERIOD_NS;

endpackage

// file: hw/sssr_top.sv
`timescale 1ns/1ps

// ***************************************************
// word buffer between the latch and the user stream
// ***************************************************
module sssr_fifo
#(
   parameter int WIDTH = sssr_pkg::SSSR_STAGES,
   parameter int DEPTH = sssr_pkg::SSSR_FIFO_DEPTH
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   import sssr_pkg::*;

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] fill;
   logic push;
   logic pop;

   // handshakes from the fill level, no look-ahead
   assign in_ready = (fill != FULL_COUNT);
   assign out_valid = (fill != '0);
   assign push = clk_en && in_valid && in_ready;
   assign pop = clk_en && out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   // storage, written only on an accepted push
   always_ff @(posedge sys_clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   // write pointer wraps at the configured depth
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         wr_ptr <= '0;
      end
      else if (push)
      begin
         wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
      end
   end

   // read pointer wraps the same way
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rd_ptr <= '0;
      end
      else if (pop)
      begin
         rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
      end
   end

   // fill level; simultaneous push and pop leaves it alone
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         fill <= '0;
      end
      else if (push && !pop)
      begin
         fill <= fill + 1'b1;
      end
      else if (pop && !push)
      begin
         fill <= fill - 1'b1;
      end
   end

endmodule

// ***************************************************
// serial shift and store register, sampled in sys_clk
// ***************************************************
module sssr_top
#(
   parameter int STAGES = sssr_pkg::SSSR_STAGES,
   parameter int FIFO_DEPTH = sssr_pkg::SSSR_FIFO_DEPTH
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic shift_clock,
   input wire logic serial_data_in,
   input wire logic latch_strobe,
   input wire logic drive_enable,
   output logic [STAGES-1:0] parallel_out,
   output logic [STAGES-1:0] parallel_out_oe,
   output logic last_parallel_out,
   output logic last_parallel_out_oe,
   output logic early_cascade_out,
   output logic late_cascade_out,
   output logic [STAGES-1:0] word_data,
   output logic word_valid,
   input wire logic word_ready,
   output logic capture_ready,
   output logic word_dropped
);
   import sssr_pkg::*;

   // ***************************************************
   // pin synchronisers
   // ***************************************************
   logic [SSSR_PIN_COUNT-1:0] pin_raw;
   logic [SSSR_PIN_COUNT-1:0] pin_meta;
   logic [SSSR_PIN_COUNT-1:0] pin_sync;
   logic clock_prev;
   logic strobe_prev;
   logic rise;
   logic fall;
   logic strobe_fall;
   logic data_bit;
   logic strobe_on;
   logic drive_on;

   assign pin_raw[SSSR_PIN_CLOCK] = shift_clock;
   assign pin_raw[SSSR_PIN_DATA] = serial_data_in;
   assign pin_raw[SSSR_PIN_STROBE] = latch_strobe;
   assign pin_raw[SSSR_PIN_DRIVE] = drive_enable;

   // two flops per pin; the meta stage feeds only the second
   // flop, and data rides the same delay as the clock so the
   // bit seen at a rising edge is the one set up before it
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pin_meta <= SSSR_SYNC_RESET;
         pin_sync <= SSSR_SYNC_RESET;
      end
      else if (clk_en)
      begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   // previous synced levels for edge detection
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         clock_prev <= SSSR_BIT_RESET;
         strobe_prev <= SSSR_BIT_RESET;
      end
      else if (clk_en)
      begin
         clock_prev <= pin_sync[SSSR_PIN_CLOCK];
         strobe_prev <= pin_sync[SSSR_PIN_STROBE];
      end
   end

   // edges of the synced pins, gated by the enable
   assign data_bit = pin_sync[SSSR_PIN_DATA];
   assign strobe_on = pin_sync[SSSR_PIN_STROBE];
   assign drive_on = pin_sync[SSSR_PIN_DRIVE];
   assign rise = clk_en && pin_sync[SSSR_PIN_CLOCK] && !clock_prev;
   assign fall = clk_en && !pin_sync[SSSR_PIN_CLOCK] && clock_prev;
   assign strobe_fall = clk_en && !strobe_on && strobe_prev;

   // ***************************************************
   // shift register and storage latch
   // ***************************************************
   logic [STAGES-1:0] shift_reg;
   logic [STAGES-1:0] latch;
   logic [STAGES-1:0] next_shift;
   logic late_bit;

   // stage zero takes the data pin, the rest move up by one
   assign next_shift = {shift_reg[STAGES-2:0], data_bit};

   // a move only on a shift clock rising edge
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         shift_reg <= SSSR_SHIFT_RESET;
      end
      else if (rise)
      begin
         shift_reg <= next_shift;
      end
   end

   // transparent while strobe is high; takes the fresh shift
   // value on the very edge so a high strobe adds no lag
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         latch <= SSSR_LATCH_RESET;
      end
      else if (clk_en && strobe_on)
      begin
         latch <= rise ? next_shift : shift_reg;
      end
   end

   // late cascade moves only on a falling shift clock edge
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         late_bit <= SSSR_BIT_RESET;
      end
      else if (fall)
      begin
         late_bit <= shift_reg[STAGES-1];
      end
   end

   // ***************************************************
   // pin drivers
   // ***************************************************
   logic drive_q;

   // enable registered with the data so both change together
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         drive_q <= SSSR_BIT_RESET;
      end
      else if (clk_en)
      begin
         drive_q <= drive_on;
      end
   end

   // one driver enable per parallel bit; strobe and data
   // never reach the enables, so a low enable always floats
   genvar gi;
   generate
      for (gi = 0; gi < STAGES; gi++)
      begin : g_par
         assign parallel_out[gi] = latch[gi];
         assign parallel_out_oe[gi] = drive_q;
      end
   endgenerate

   assign last_parallel_out = latch[STAGES-1];
   assign last_parallel_out_oe = drive_q;
   // cascade taps ignore the enable, so chains keep running
   assign early_cascade_out = shift_reg[STAGES-1];
   assign late_cascade_out = late_bit;

   // ***************************************************
   // word stream of completed latch loads
   // ***************************************************
   logic push_ready;
   logic dropped;

   // one word per strobe pulse, taken as the strobe closes; a
   // controller that keeps strobe low while shifting gets
   // exactly one word per byte
   sssr_fifo #(
      .WIDTH(STAGES),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .in_data(latch),
      .in_valid(strobe_fall),
      .in_ready(push_ready),
      .out_data(word_data),
      .out_valid(word_valid),
      .out_ready(word_ready)
   );

   // the pins cannot be stalled, so a full buffer loses the
   // word; sticky flag, cleared only by reset
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         dropped <= SSSR_BIT_RESET;
      end
      else if (strobe_fall && !push_ready)
      begin
         dropped <= 1'b1;
      end
   end

   assign capture_ready = push_ready;
   assign word_dropped = dropped;

endmodule

// file: bench/sssr_props.sv
`timescale 1ns/1ps
// *****
// pin to output timing watch
// *****
module sssr_props
#(
   parameter int STAGES = sssr_pkg::SSSR_STAGES
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic shift_clock,
   input wire logic latch_strobe,
   input wire logic drive_enable,
   input wire logic [STAGES-1:0] parallel_out,
   input wire logic [STAGES-1:0] parallel_out_oe,
   input wire logic last_parallel_out,
   input wire logic last_parallel_out_oe,
   input wire logic early_cascade_out,
   input wire logic late_cascade_out,
   input wire logic word_valid
);
   import sssr_pkg::*;
   logic [4:0] rst_hist;
   logic quiet;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // pin history is void for a few edges after reset
   always_ff @(posedge sys_clk)
   begin
      rst_hist <= {rst_hist[3:0], reset};
   end
   assign quiet = (rst_hist == 5'h0);
   // two sync flops plus one register: outputs move three edges after a pin
   a_early_on_rise: assert property (
      quiet && $changed(early_cascade_out) |-> $past(shift_clock, 3) && !$past(shift_clock, 4))
      else $error("early cascade moved without a rise");
   a_late_on_fall: assert property (
      quiet && $changed(late_cascade_out) |-> !$past(shift_clock, 3) && $past(shift_clock, 4))
      else $error("late cascade moved without a fall");
   a_latch_on_strobe: assert property (
      quiet && $changed(parallel_out) |-> $past(latch_strobe, 3))
      else $error("latch moved with strobe low");
   a_drive_follows: assert property (
      quiet |-> parallel_out_oe == {STAGES{$past(drive_enable, 3)}})
      else $error("output enable off its pin");
   a_float_together: assert property (
      !parallel_out_oe[0] |-> parallel_out_oe == '0 && !last_parallel_out_oe)
      else $error("partial float");
   a_last_mirror: assert property (
      last_parallel_out == parallel_out[STAGES-1]
      && last_parallel_out_oe == parallel_out_oe[STAGES-1])
      else $error("last output differs from bit seven");
   c_shift: cover property ($changed(early_cascade_out));
   c_late: cover property ($changed(late_cascade_out));
   c_word: cover property ($rose(word_valid));
endmodule

bind sssr_top sssr_props #(.STAGES(STAGES)) sssr_props_inst (.sys_clk, .reset,
   .shift_clock, .latch_strobe, .drive_enable, .parallel_out, .parallel_out_oe,
   .last_parallel_out, .last_parallel_out_oe, .early_cascade_out, .late_cascade_out,
   .word_valid);

// file: bench/sssr_ctrl_model.sv
`timescale 1ns/1ps
// *****
// serial controller on the pin side
// *****
module sssr_ctrl_model
(
   input wire logic sys_clk,
   output logic shift_clock,
   output logic serial_data_in,
   output logic latch_strobe,
   output logic drive_enable
);
   import sssr_pkg::*;
   // pins idle low, so no edge shows at reset release
   initial
   begin
      shift_clock = 1'b0;
      serial_data_in = 1'b0;
      latch_strobe = 1'b0;
      drive_enable = 1'b0;
   end
   // msb first; data moves with the falling clock, well clear of the rise
   task send_byte(input logic [7:0] b, input int half);
      for (int i = 7; i >= 0; i--)
      begin
         shift_clock <= 1'b0;
         serial_data_in <= b[i];
         repeat (half) @(posedge sys_clk);
         shift_clock <= 1'b1;
         repeat (half) @(posedge sys_clk);
      end
      shift_clock <= 1'b0;
      serial_data_in <= ~b[0]; // hold over: inverse
   endtask
   // one strobe pulse per completed byte
   task pulse(input int len);
      latch_strobe <= 1'b1;
      repeat (len) @(posedge sys_clk);
      latch_strobe <= 1'b0;
   endtask
   task enable(input logic v);
      drive_enable <= v;
   endtask
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
// *****
// bench for the shift and store register
// *****
module testbench;
   import sssr_pkg::*;
   logic sys_clk = 1'b0;
   logic reset;
   logic clk_en;
   logic word_ready;
   logic shift_clock, serial_data_in, latch_strobe, drive_enable;
   logic [7:0] parallel_out, parallel_out_oe, word_data;
   logic last_parallel_out, last_parallel_out_oe, early_cascade_out, late_cascade_out;
   logic word_valid, capture_ready, word_dropped;
   int failures = 0;
   int samples_checked = 0;
   // 125 MHz
   always #4 sys_clk = ~sys_clk;
   sssr_ctrl_model sssr_ctrl_model_inst (.sys_clk, .shift_clock, .serial_data_in,
      .latch_strobe, .drive_enable);
   sssr_top sssr_top_inst (.sys_clk, .reset, .clk_en, .shift_clock, .serial_data_in,
      .latch_strobe, .drive_enable, .parallel_out, .parallel_out_oe, .last_parallel_out,
      .last_parallel_out_oe, .early_cascade_out, .late_cascade_out, .word_data,
      .word_valid, .word_ready, .capture_ready, .word_dropped);
   task chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // three edge pin latency plus margin
   task settle;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task pop;
      @(posedge sys_clk);
      word_ready <= 1'b1;
      @(posedge sys_clk);
      word_ready <= 1'b0;
   endtask
   task t_shift_hold;
      @(posedge sys_clk);
      sssr_ctrl_model_inst.enable(1'b1);
      sssr_ctrl_model_inst.send_byte(8'ha5, 2);
      settle;
      chk(parallel_out, 8'h00);
      chk(early_cascade_out, 1'b1);
      chk(late_cascade_out, 1'b1);
      chk(parallel_out_oe, 8'hff);
      @(posedge sys_clk);
      sssr_ctrl_model_inst.pulse(2);
      settle;
      chk(parallel_out, 8'ha5);
      chk(last_parallel_out, 1'b1);
      chk(word_data, 8'ha5);
      pop;
   endtask
   task t_float;
      @(posedge sys_clk);
      sssr_ctrl_model_inst.enable(1'b0);
      sssr_ctrl_model_inst.send_byte(8'h3c, 5);
      sssr_ctrl_model_inst.pulse(3);
      settle;
      chk(parallel_out_oe, 8'h00);
      chk(last_parallel_out_oe, 1'b0);
      chk(early_cascade_out, 1'b0);
      chk(parallel_out, 8'h3c);
      pop;
   endtask
   // strobe held high across the shift: latch tracks mid-byte
   task t_transparent;
      @(posedge sys_clk);
      sssr_ctrl_model_inst.enable(1'b1);
      fork
         sssr_ctrl_model_inst.pulse(40);
         sssr_ctrl_model_inst.send_byte(8'h96, 2);
         begin
            repeat (19) @(posedge sys_clk);
            @(negedge sys_clk);
            chk(parallel_out, 8'hc9);
         end
      join
      settle;
      chk(parallel_out, 8'h96);
      pop;
   endtask
   // far side stalls while seventeen words arrive; the last is lost
   task t_fill;
      for (int i = 0; i < 17; i++)
      begin
         @(posedge sys_clk);
         sssr_ctrl_model_inst.send_byte(8'(i * 17), 2);
         sssr_ctrl_model_inst.pulse(2);
      end
      settle;
      chk(capture_ready, 1'b0);
      chk(word_dropped, 1'b1);
      @(posedge sys_clk);
      word_ready <= 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         @(negedge sys_clk);
         chk(word_data, 8'(i * 17));
         @(posedge sys_clk);
      end
      word_ready <= 1'b0;
      @(negedge sys_clk);
      chk(word_valid, 1'b0);
   endtask
   // enable low freezes the pop and the shift path; pins end idle so
   // resuming shows no stale edge
   task t_freeze;
      @(posedge sys_clk);
      sssr_ctrl_model_inst.send_byte(8'h5a, 2);
      sssr_ctrl_model_inst.pulse(2);
      settle;
      @(posedge sys_clk);
      clk_en <= 1'b0;
      word_ready <= 1'b1;
      sssr_ctrl_model_inst.send_byte(8'hff, 2);
      settle;
      chk(word_valid, 1'b1);
      chk(word_data, 8'h5a);
      chk(early_cascade_out, 1'b0);
      chk(parallel_out, 8'h5a);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      word_ready <= 1'b0;
      settle;
      chk(word_valid, 1'b1);
      chk(early_cascade_out, 1'b0);
      pop;
   endtask
   // reset in mid-run clears state and the sticky drop flag
   task t_reset;
      @(posedge sys_clk);
      sssr_ctrl_model_inst.send_byte(8'hc3, 2);
      sssr_ctrl_model_inst.pulse(2);
      settle;
      chk(parallel_out, 8'hc3);
      chk(late_cascade_out, 1'b1);
      chk(word_valid, 1'b1);
      chk(word_dropped, 1'b1);
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      settle;
      chk(parallel_out, 8'h00);
      chk(early_cascade_out, 1'b0);
      chk(late_cascade_out, 1'b0);
      chk(word_valid, 1'b0);
      chk(capture_ready, 1'b1);
      chk(word_dropped, 1'b0);
      chk(parallel_out_oe, 8'hff);
   endtask
   task results;
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // main sequence
   initial
   begin
      reset <= 1'b1;
      clk_en <= 1'b1;
      word_ready <= 1'b0;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      settle;
      chk(parallel_out_oe, 8'h00);
      t_shift_hold;
      t_float;
      t_transparent;
      t_fill;
      t_freeze;
      t_reset;
      results;
   end
   // whole run needs about 950 cycles
   initial
   begin
      repeat (4000) @(posedge sys_clk);
      failures++;
      results;
   end
endmodule
